// ### psc_map.svh
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH
// ==================================
// register word indices (byte address = index * 4)
`define PSC_IDX_EVT 10'h018
`define PSC_IDX_STRAP 10'h019
`define PSC_IDX_DIAG 10'h01E
`define PSC_IDX_RST 10'h01F
`define PSC_IDX_LSR 10'h180
// ==================================
// field positions and reset values
`define PSC_EVT_EN_RST 8'h08
`define PSC_RST_RW_MASK 16'hFFDF
`define PSC_DIAG_START 15
`define PSC_DIAG_AUTO 14
`define PSC_RST_GLB 15
`define PSC_RST_DIG 14
`define PSC_STRAP_W 5
`define PSC_STRAP_CAP 2'h2
`define PSC_STRAP_END 2'h3
// ==================================
// bus answers
`define PSC_RESP_OK 2'h0
`define PSC_RESP_ERR 2'h2
`endif

// ### psc_pkg.sv
`default_nettype none
package psc_pkg;
  typedef logic [31:0] psc_word_t;
  typedef logic [11:0] psc_addr_t;
  typedef logic [15:0] psc_reg_t;
  typedef enum logic [1:0] {
    PSC_TDR_IDLE = 2'h0,
    PSC_TDR_RUN = 2'h1,
    PSC_TDR_FIN = 2'h3
  } psc_tdr_e;
endpackage
`default_nettype wire

// ### psc_sync.sv
`default_nettype none
module psc_sync #(
  parameter int W = 5
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // pins and synchronised copy
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] meta_q;
  // ==================================
  // two flops; only the second stage is read
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      syncOut <= '0;
    end else begin
      meta_q <= pinIn;
      syncOut <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### psc_tdr.sv
`include "psc_map.svh"
`default_nettype none
module psc_tdr (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // control
  input wire logic launch,
  input wire logic abort,
  input wire logic clrFlags,
  // measurement engine
  input wire logic measDone,
  input wire logic measFail,
  output logic tdrReq,
  // status
  output psc_pkg::psc_tdr_e state,
  output logic busy,
  output logic doneFlag,
  output logic failFlag
);
  import psc_pkg::*;
  psc_tdr_e state_d;
  // ==================================
  // sequencer
  always_comb begin
    state_d = state;
    case (state)
      PSC_TDR_IDLE: begin
        if (launch) begin
          state_d = PSC_TDR_RUN;
        end
      end
      PSC_TDR_RUN: begin
        if (measDone) begin
          state_d = PSC_TDR_FIN;
        end
      end
      PSC_TDR_FIN: begin
        state_d = PSC_TDR_IDLE;
      end
      default: begin
        state_d = PSC_TDR_IDLE;
      end
    endcase
  end
  assign busy = (state == PSC_TDR_RUN);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= PSC_TDR_IDLE;
      tdrReq <= 1'b0;
    end else if (abort) begin
      state <= PSC_TDR_IDLE;
      tdrReq <= 1'b0;
    end else begin
      state <= state_d;
      tdrReq <= (state == PSC_TDR_IDLE) && launch;
    end
  end
  // ==================================
  // done and fail flags
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      doneFlag <= 1'b0;
      failFlag <= 1'b0;
    end else if (clrFlags || (launch && state == PSC_TDR_IDLE)) begin
      doneFlag <= 1'b0;
      failFlag <= 1'b0;
    end else if (busy && measDone && !abort) begin
      doneFlag <= 1'b1;
      failFlag <= measFail;
    end
  end
  AST_TDR_DONE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    busy && measDone && !abort && !clrFlags |=> doneFlag && !busy)
    else $error("diag completion not reported");
  AST_TDR_REQ: assert property (@(posedge clk_sys) disable iff (!rst_b)
    state == PSC_TDR_IDLE && launch && !abort |=> tdrReq ##1 !tdrReq)
    else $error("diag request not a single pulse");
endmodule
`default_nettype wire

// ### psc_regs_top.sv
// Notes on behaviour
// - Status bit 15 latches a maintenance_channel ack-received event; enable bit 7 resets to 0.
// - Status bit 14 latches a transmit-valid-cleared event; its enable sits in bit 6.
// - Status bit 11 flags power-on reset done; its enable bit 3 alone resets to one.
// - Status bit 10 flags no frames detected; enable bit 2 resets to zero.
// - Status bit 9 flags a wake request and bit 8 a low-power event; enables 1 and 0 reset to 0.
// - The five-bit strap_mgmt_address is caught from straps and read back in bits 4 to 0.
// - Writing one to diag bit 15 starts a measurement that self-clears; bit 1 done, bit 0 fail.
// - With auto-run bit 14 set a measurement starts on every link-down seen while the sequencer is idle; else only manually.
// - Reset bit 15 clears the digital logic and the event, diag and reset registers, re-catches the straps, then reads zero.
// - Reset bit 14 resets only the digital core, keeping registers, then reads zero.
// - Link state bit 15 shows link up from control_status_logic and bit 12 link status.
// - Link state bit 14 shows link down as judged by control_status_logic.
// - Link state bits 13, 2, 1, 0 show send-data, descrambler lock, local and remote receiver.
//
// Design decision made here: the AXI4-Lite register port.
`include "psc_map.svh"
`default_nettype none
module psc_regs_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // axi4-lite write address
  input wire psc_pkg::psc_addr_t awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire psc_pkg::psc_word_t wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire psc_pkg::psc_addr_t araddr,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output psc_pkg::psc_word_t rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // core event pulses
  input wire logic evAckRcvd,
  input wire logic evTxValidClr,
  input wire logic evNoFrame,
  input wire logic evWakeReq,
  input wire logic evLowPower,
  // control_status_logic levels
  input wire logic linkUp,
  input wire logic linkDown,
  input wire logic ctrlSendData,
  input wire logic linkStatus,
  input wire logic descrLock,
  input wire logic locRcvrOk,
  input wire logic remRcvrOk,
  // strap pins
  input wire logic [4:0] strapMgmtAddress,
  // cable diagnostic engine
  output logic tdrReq,
  input wire logic tdrMeasDone,
  input wire logic tdrMeasFail,
  // system outputs
  output logic irq,
  output logic coreRst
);
  import psc_pkg::*;

  // ==================================
  // state
  logic [5:0] evtSts_q;
  logic [5:0] evtSts_d;
  logic [7:0] evtEn_q;
  logic porPend_q;
  logic cfgAuto_q;
  psc_reg_t rstCtl_q;
  psc_reg_t rstCtl_d;
  logic [6:0] lsr_q;
  logic [4:0] strapAddr_q;
  logic [1:0] strapCnt_q;
  logic [4:0] strapSync;
  logic linkDownPrev_q;
  psc_addr_t awAddr_q;
  psc_addr_t arAddr_q;
  psc_reg_t wData_q;
  logic [1:0] wStrb_q;

  // ==================================
  // bus decode
  wire logic wrEn = !awready && !wready && !bvalid;
  wire logic rdEn = !arready && !rvalid;
  wire logic awHs = awvalid && awready;
  wire logic wHs = wvalid && wready;
  wire logic arHs = arvalid && arready;
  wire logic bHs = bvalid && bready;
  wire logic rHs = rvalid && rready;
  wire logic [9:0] wIdx = awAddr_q[11:2];
  wire logic [9:0] rIdx = arAddr_q[11:2];
  wire logic wHitEvt = (wIdx == `PSC_IDX_EVT);
  wire logic wHitDiag = (wIdx == `PSC_IDX_DIAG);
  wire logic wHitRst = (wIdx == `PSC_IDX_RST);
  wire logic wHitRo = (wIdx == `PSC_IDX_STRAP) || (wIdx == `PSC_IDX_LSR);
  wire logic wMapped = wHitEvt || wHitDiag || wHitRst || wHitRo;
  wire logic rHitEvt = (rIdx == `PSC_IDX_EVT);
  wire logic rHitStrap = (rIdx == `PSC_IDX_STRAP);
  wire logic rHitDiag = (rIdx == `PSC_IDX_DIAG);
  wire logic rHitRst = (rIdx == `PSC_IDX_RST);
  wire logic rHitLsr = (rIdx == `PSC_IDX_LSR);
  wire logic rMapped = rHitEvt || rHitStrap || rHitDiag || rHitRst || rHitLsr;
  wire psc_reg_t laneMask = {{8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  wire psc_reg_t wBits = wData_q & laneMask;

  // ==================================
  // reset commands
  wire logic glbRst = rstCtl_q[`PSC_RST_GLB];
  wire logic digRst = rstCtl_q[`PSC_RST_DIG];

  // ==================================
  // event register
  wire logic [5:0] evtSet = {evAckRcvd, evTxValidClr, porPend_q, evNoFrame, evWakeReq,
                             evLowPower};
  wire logic [5:0] enSel = {evtEn_q[7], evtEn_q[6], evtEn_q[3:0]};
  wire logic rdClr = rdEn && rHitEvt;
  wire logic evtWr = wrEn && wHitEvt;
  wire psc_reg_t evtView = {evtSts_q[5:4], 2'h0, evtSts_q[3:0], evtEn_q};

  // ==================================
  // diagnostic and strap wiring
  logic tdrBusy;
  logic tdrDone;
  logic tdrFail;
  psc_tdr_e tdrState;
  wire logic diagWr = wrEn && wHitDiag;
  wire logic manStart = diagWr && wStrb_q[1] && wData_q[`PSC_DIAG_START];
  wire logic downRise = lsr_q[5] && !linkDownPrev_q;
  wire logic tdrLaunch = manStart || (cfgAuto_q && downRise);
  wire psc_reg_t diagView = {tdrBusy, cfgAuto_q, 12'h000, tdrDone, tdrFail};
  wire psc_reg_t lsrView = {lsr_q[6:3], 9'h000, lsr_q[2:0]};
  wire psc_reg_t strapView = {11'h000, strapAddr_q};

  // ==================================
  // read selection
  wire psc_reg_t rdMux = rHitEvt ? evtView :
                         rHitStrap ? strapView :
                         rHitDiag ? diagView :
                         rHitRst ? rstCtl_q :
                         rHitLsr ? lsrView : 16'h0000;

  // ==================================
  // sticky status, set wins over read clear
  assign evtSts_d = (evtSts_q & ~{6{rdClr}}) | evtSet;

  // ==================================
  // self-clearing commands
  always_comb begin
    rstCtl_d = rstCtl_q & ~16'hC000;
    if (wrEn && wHitRst) begin
      rstCtl_d = (rstCtl_d & ~(laneMask & `PSC_RST_RW_MASK)) | (wBits & `PSC_RST_RW_MASK);
    end
  end

  // ==================================
  // axi write channel
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `PSC_RESP_OK;
      awAddr_q <= 12'h000;
      wData_q <= 16'h0000;
      wStrb_q <= 2'h0;
    end else begin
      if (awHs) begin
        awready <= 1'b0;
        awAddr_q <= awaddr;
      end
      if (wHs) begin
        wready <= 1'b0;
        wData_q <= wdata[15:0];
        wStrb_q <= wstrb[1:0];
      end
      if (wrEn) begin
        bvalid <= 1'b1;
        bresp <= wMapped ? `PSC_RESP_OK : `PSC_RESP_ERR;
      end else if (bHs) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ==================================
  // axi read channel
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `PSC_RESP_OK;
      arAddr_q <= 12'h000;
    end else if (arHs) begin
      arready <= 1'b0;
      arAddr_q <= araddr;
    end else if (rdEn) begin
      rvalid <= 1'b1;
      rdata <= {16'h0000, rdMux};
      rresp <= rMapped ? `PSC_RESP_OK : `PSC_RESP_ERR;
    end else if (rHs) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ==================================
  // register file; the global command clears it, the digital one does not
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      evtSts_q <= 6'h00;
      evtEn_q <= `PSC_EVT_EN_RST;
      porPend_q <= 1'b1;
      cfgAuto_q <= 1'b0;
      rstCtl_q <= 16'h0000;
    end else if (glbRst) begin
      evtSts_q <= 6'h00;
      evtEn_q <= `PSC_EVT_EN_RST;
      porPend_q <= 1'b1;
      cfgAuto_q <= 1'b0;
      rstCtl_q <= 16'h0000;
    end else begin
      evtSts_q <= evtSts_d;
      porPend_q <= 1'b0;
      rstCtl_q <= rstCtl_d;
      if (evtWr) begin
        evtEn_q <= (evtEn_q & ~laneMask[7:0]) | wBits[7:0];
      end
      if (diagWr && wStrb_q[1]) begin
        cfgAuto_q <= wData_q[`PSC_DIAG_AUTO];
      end
    end
  end

  // ==================================
  // link state snapshot
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lsr_q <= 7'h00;
      linkDownPrev_q <= 1'b0;
    end else begin
      lsr_q <= {linkUp, linkDown, ctrlSendData, linkStatus, descrLock, locRcvrOk, remRcvrOk};
      linkDownPrev_q <= lsr_q[5];
    end
  end

  // ==================================
  // strap capture, three edges after release so the synchroniser is settled
  psc_sync #(
    .W(`PSC_STRAP_W)
  ) u_strap_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .pinIn(strapMgmtAddress),
    .syncOut(strapSync)
  );
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      strapCnt_q <= 2'h0;
      strapAddr_q <= 5'h00;
    end else if (glbRst) begin
      strapCnt_q <= 2'h0;
    end else if (strapCnt_q != `PSC_STRAP_END) begin
      strapCnt_q <= strapCnt_q + 2'h1;
      if (strapCnt_q == `PSC_STRAP_CAP) begin
        strapAddr_q <= strapSync;
      end
    end
  end

  // ==================================
  // cable diagnostic sequencer
  psc_tdr u_tdr (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .launch(tdrLaunch),
    .abort(glbRst || digRst),
    .clrFlags(glbRst),
    .measDone(tdrMeasDone),
    .measFail(tdrMeasFail),
    .tdrReq(tdrReq),
    .state(tdrState),
    .busy(tdrBusy),
    .doneFlag(tdrDone),
    .failFlag(tdrFail)
  );

  // ==================================
  // interrupt and core reset outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
      coreRst <= 1'b0;
    end else begin
      irq <= |(evtSts_q & enSel);
      coreRst <= glbRst || digRst;
    end
  end

  // ==================================
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  AST_IRQ_SET: assert property ((|(evtSts_q & enSel)) |=> irq)
    else $error("masked-in status did not raise the interrupt");
  AST_IRQ_CLR: assert property (!(|(evtSts_q & enSel)) |=> !irq)
    else $error("interrupt high without enabled status");
  AST_ACK_STICKY: assert property (evAckRcvd && !glbRst |=> evtSts_q[5])
    else $error("ack event lost");
  AST_RD_CLEAR: assert property (rdClr && !glbRst && evtSet == 6'h00 |=> evtSts_q == 6'h00)
    else $error("status not cleared by read");
  AST_STS_NOWRITE: assert property (evtWr && !rdClr && !glbRst && evtSet == 6'h00
    |=> evtSts_q == $past(evtSts_q))
    else $error("write changed status bits");
  AST_GLB_RST: assert property (glbRst |=> !glbRst && evtEn_q == `PSC_EVT_EN_RST && !cfgAuto_q
    ##1 evtSts_q[3])
    else $error("global reset did not restore defaults and flag power-on done");
  AST_DIG_KEEP: assert property (digRst && !glbRst && !wrEn
    |=> !digRst && $stable(evtEn_q) && $stable(cfgAuto_q) && coreRst)
    else $error("digital reset disturbed registers");
  AST_AUTO_RUN: assert property (cfgAuto_q && downRise && tdrState == PSC_TDR_IDLE
    && !glbRst && !digRst |=> tdrBusy)
    else $error("link down did not start a diagnostic");
  AST_NO_AUTO: assert property (!manStart && !cfgAuto_q && tdrState == PSC_TDR_IDLE
    |=> !tdrBusy)
    else $error("diagnostic started without a request");
  AST_LSR_DOWN: assert property (linkDown |=> lsr_q[5])
    else $error("link down not shown");
  AST_STRAP: assert property (strapCnt_q == `PSC_STRAP_CAP && !glbRst
    |=> strapAddr_q == $past(strapSync))
    else $error("strap address not captured");
  AST_BRESP: assert property (wrEn |=> bvalid ##0 !awready ##0 !wready)
    else $error("write response missing");
endmodule
`default_nettype wire

// ### testbench.sv
`default_nettype none
module testbench import psc_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  // ==================================
  // signals
  logic clk_sys, rst_b;
  psc_addr_t awaddr, araddr;
  psc_word_t wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [4:0] ev, strap;
  logic [6:0] lv;
  logic tdrReq, tdrMeasDone, tdrMeasFail, irq, coreRst;
  int err_total, tests_run, tdrCnt, rstCnt, seed, sb;
  int sbTab[5] = '{8, 9, 10, 14, 15};
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [33:0] re;

  psc_regs_top u_psc_regs_top (
    .clk_sys(clk_sys), .rst_b(rst_b),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .evAckRcvd(ev[4]), .evTxValidClr(ev[3]), .evNoFrame(ev[2]),
    .evWakeReq(ev[1]), .evLowPower(ev[0]),
    .linkUp(lv[6]), .linkDown(lv[5]), .ctrlSendData(lv[4]), .linkStatus(lv[3]),
    .descrLock(lv[2]), .locRcvrOk(lv[1]), .remRcvrOk(lv[0]),
    .strapMgmtAddress(strap),
    .tdrReq(tdrReq), .tdrMeasDone(tdrMeasDone), .tdrMeasFail(tdrMeasFail),
    .irq(irq), .coreRst(coreRst)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ==================================
  // checking
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // sampled at the falling edge: flops are settled, and a handshake seen
  // here completes at the next rising edge since the bench holds ready
  always @(negedge clk_sys) begin
    if (tdrReq === 1'b1) tdrCnt++;
    if (coreRst === 1'b1) rstCnt++;
    if (rvalid && rready) begin
      re = rq.pop_front();
      chk("rdata", re[31:0], rdata);
      chk("rresp", {30'h0, re[33:32]}, {30'h0, rresp});
    end
    if (bvalid && bready) chk("bresp", {30'h0, bq.pop_front()}, {30'h0, bresp});
  end

  // ==================================
  // bus master
  task automatic wr(input psc_addr_t a, input logic [15:0] d, input logic [1:0] r);
    logic ha, hw, hb;
    @(posedge clk_sys);
    bq.push_back(r);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk_sys);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bready && bvalid;
      @(posedge clk_sys);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end while (!hb);
  endtask

  task automatic rd(input psc_addr_t a, input logic [1:0] r, input logic [31:0] d);
    logic ha, hr;
    @(posedge clk_sys);
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk_sys);
      ha = arvalid && arready;
      hr = rvalid && rready;
      @(posedge clk_sys);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
    end while (!hr);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic meas(input logic f);
    @(posedge clk_sys);
    tdrMeasDone <= 1'b1;
    tdrMeasFail <= f;
    @(posedge clk_sys);
    tdrMeasDone <= 1'b0;
    tdrMeasFail <= 1'b0;
  endtask

  // ==================================
  // watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    end_sim;
  end

  // ==================================
  // sequence
  initial begin
    seed = 77;
    err_total = 0;
    tests_run = 0;
    tdrCnt = 0;
    rstCnt = 0;
    rst_b = 1'b0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'h3;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    ev = 5'h00;
    lv = 7'h00;
    tdrMeasDone = 1'b0;
    tdrMeasFail = 1'b0;
    strap = 5'($random(seed));
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    cyc(4);
    chk("irq", 32'h1, {31'h0, irq});
    rd(12'h060, 2'h0, 32'h0808);
    rd(12'h060, 2'h0, 32'h0008);
    cyc(3);
    chk("irq", 32'h0, {31'h0, irq});
    rd(12'h064, 2'h0, {27'h0, strap});
    // upper lane only: the enable byte must keep its reset value
    wstrb <= 4'h2;
    wr(12'h060, 16'h00F7, 2'h0);
    rd(12'h060, 2'h0, 32'h0008);
    wstrb <= 4'h3;
    wr(12'h060, 16'hFF00, 2'h0);
    rd(12'h060, 2'h0, 32'h0000);
    // each event: masked first, then enabled, then cleared by the read
    for (int i = 0; i < 5; i++) begin
      sb = sbTab[i];
      @(posedge clk_sys);
      ev <= 5'h01 << i;
      @(posedge clk_sys);
      ev <= 5'h00;
      cyc(3);
      chk("irq", 32'h0, {31'h0, irq});
      wr(12'h060, 16'h0001 << (sb - 8), 2'h0);
      cyc(3);
      chk("irq", 32'h1, {31'h0, irq});
      rd(12'h060, 2'h0, (32'h1 << sb) | (32'h1 << (sb - 8)));
      cyc(3);
      chk("irq", 32'h0, {31'h0, irq});
    end
    // random levels, then their inverse, so every bit is seen both ways
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      lv <= (k == 0) ? 7'($random(seed)) : ~lv;
      cyc(3);
      rd(12'h600, 2'h0, {16'h0, lv[6:3], 9'h000, lv[2:0]});
    end
    chk("tdrReq count", 32'h0, 32'(tdrCnt));
    wr(12'h078, 16'h8000, 2'h0);
    cyc(2);
    chk("tdrReq count", 32'h1, 32'(tdrCnt));
    rd(12'h078, 2'h0, 32'h8000);
    meas(1'b1);
    cyc(2);
    rd(12'h078, 2'h0, 32'h0003);
    wr(12'h078, 16'h4000, 2'h0);
    @(posedge clk_sys);
    lv[5] <= 1'b0;
    cyc(3);
    lv[5] <= 1'b1;
    cyc(4);
    chk("tdrReq count", 32'h2, 32'(tdrCnt));
    rd(12'h078, 2'h0, 32'hC000);
    meas(1'b0);
    cyc(2);
    rd(12'h078, 2'h0, 32'h4002);
    wr(12'h07C, 16'h00FF, 2'h0);
    wr(12'h07C, 16'h40DF, 2'h0);
    cyc(2);
    chk("coreRst count", 32'h1, 32'(rstCnt));
    rd(12'h07C, 2'h0, 32'h00DF);
    rd(12'h078, 2'h0, 32'h4002);
    wr(12'h07C, 16'h8000, 2'h0);
    cyc(4);
    chk("coreRst count", 32'h2, 32'(rstCnt));
    rd(12'h07C, 2'h0, 32'h0000);
    rd(12'h078, 2'h0, 32'h0000);
    rd(12'h060, 2'h0, 32'h0808);
    rd(12'h064, 2'h0, {27'h0, strap});
    // unmapped places answer with an error
    rd(12'h100, 2'h2, 32'h0000);
    wr(12'h104, 16'h1234, 2'h2);
    cyc(2);
    end_sim;
  end
endmodule
`default_nettype wire
